/* File: hdl/ucdma_channels.sv */
// Two DMA channels: configuration registers and packet sequencing.
// Assumes the processor bus and the buffer manager run on CLK.
`timescale 1ns/10ps

module ucdma_channels
    import ucdma_pkg::*;
#(
    parameter int NUM_CH = UCDMA_NUM_CH
) (
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    input  wire logic [15:0] ADDR,
    input  wire logic        WR_EN,
    input  wire logic        RD_EN,
    input  wire logic [7:0]  WDATA,
    output logic      [7:0]  RDATA,
    input  wire logic [1:0]  PKT_READY,
    input  wire logic [1:0]  PKT_BULK,
    input  wire logic [1:0]  PKT_DONE,
    output logic      [1:0]  CH_RUN,
    output logic      [1:0]  CH_DIR_IN,
    output logic      [5:0]  CH_ENDPOINT,
    output logic      [27:0] CH_SLOT_MASK,
    output logic      [3:0]  CH_BYTES_PER_SLOT,
    output logic      [1:0]  CH_MOVE,
    output logic      [1:0]  CH_IRQ
);
    // Register layout is fixed at two channels; refuse anything else at elaboration
    if (NUM_CH != 2) begin : g_num_ch_check
        $error("ucdma_channels supports exactly two channels");
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] control   [2];
    logic [7:0] mask_high [2];
    logic [7:0] mask_low  [2];
    logic [7:0] next_control   [2];
    logic [7:0] next_mask_high [2];
    logic [7:0] next_mask_low  [2];
    logic [7:0] next_rdata;
    logic [1:0] next_move;
    logic [1:0] next_irq;
    ucdma_state_e state [2];
    ucdma_state_e next_state [2];

    // Address decode shared by write and read paths
    function automatic logic [15:0] reg_addr(input int ch, input int which);
        logic [15:0] base;
        base = (ch == 0) ? UCDMA_DMA0_CONTROL : UCDMA_DMA1_CONTROL;
        return (which == 0) ? base : (which == 1) ? base + 16'h0001 : base + 16'h0002;
    endfunction

    // Sequencer and register writes; hardware clear of run wins only
    // when no firmware write to that channel's control register lands in the same cycle, so a re-arm is kept
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            next_control[c]   = control[c];
            next_mask_high[c] = mask_high[c];
            next_mask_low[c]  = mask_low[c];
            next_state[c]     = state[c];
            next_move[c]      = 1'b0;
            next_irq[c]       = 1'b0;
            unique case (state[c])
                UCDMA_IDLE: begin
                    if (control[c][UCDMA_RUN_BIT] && PKT_READY[c]) begin
                        next_state[c] = UCDMA_MOVE;
                        next_move[c]  = 1'b1;
                    end
                end
                UCDMA_MOVE: begin
                    next_move[c] = ~PKT_DONE[c];
                    if (PKT_DONE[c]) begin
                        next_state[c] = UCDMA_DONE;
                    end
                end
                UCDMA_DONE: begin
                    next_state[c] = UCDMA_IDLE;
                    // Handshake only for bulk OUT packets
                    if (control[c][UCDMA_HSK_BIT] && PKT_BULK[c]
                        && !control[c][UCDMA_DIR_BIT]) begin
                        next_control[c][UCDMA_RUN_BIT] = 1'b0;
                        next_irq[c] = 1'b1;
                    end
                end
            endcase
            if (WR_EN && ADDR == reg_addr(c, 0)) begin
                next_control[c] = WDATA & UCDMA_CTL_WMASK;
            end
            if (WR_EN && ADDR == reg_addr(c, 1)) begin
                next_mask_high[c] = WDATA;
            end
            if (WR_EN && ADDR == reg_addr(c, 2)) begin
                next_mask_low[c] = WDATA;
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        next_rdata = RDATA;
        if (RD_EN) begin
            next_rdata = 8'h00;
            for (int c = 0; c < 2; c++) begin
                if (ADDR == reg_addr(c, 0)) next_rdata = control[c];
                if (ADDR == reg_addr(c, 1)) next_rdata = mask_high[c];
                if (ADDR == reg_addr(c, 2)) next_rdata = mask_low[c];
            end
        end
    end

    // State registers; all zero after reset except the sequencer state, which loads UCDMA_IDLE (3'b001)
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int c = 0; c < 2; c++) begin
                control[c]   <= UCDMA_RESET_VAL;
                mask_high[c] <= UCDMA_RESET_VAL;
                mask_low[c]  <= UCDMA_RESET_VAL;
                state[c]     <= UCDMA_IDLE;
            end
            RDATA  <= 8'h00;
            CH_MOVE <= 2'b00;
            CH_IRQ  <= 2'b00;
        end else begin
            for (int c = 0; c < 2; c++) begin
                control[c]   <= next_control[c];
                mask_high[c] <= next_mask_high[c];
                mask_low[c]  <= next_mask_low[c];
                state[c]     <= next_state[c];
            end
            RDATA   <= next_rdata;
            CH_MOVE <= next_move;
            CH_IRQ  <= next_irq;
        end
    end

    // Configuration outputs, registered from the next register values, so they match the registers
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            CH_RUN            <= 2'b00;
            CH_DIR_IN         <= 2'b00;
            CH_ENDPOINT       <= 6'h00;
            CH_SLOT_MASK      <= 28'h0000000;
            CH_BYTES_PER_SLOT <= 4'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                CH_RUN[c]              <= next_control[c][UCDMA_RUN_BIT];
                CH_DIR_IN[c]           <= next_control[c][UCDMA_DIR_BIT];
                CH_ENDPOINT[c*3 +: 3]  <= next_control[c][UCDMA_EP_MSB:0];
                CH_SLOT_MASK[c*14 +: 14] <= {next_mask_high[c][5:0], next_mask_low[c]};
                CH_BYTES_PER_SLOT[c*2 +: 2] <= next_mask_high[c][7:UCDMA_BPS_LSB];
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_reserved_zero;
        @(posedge CLK) disable iff (!ARST_N)
        control[0][5:4] == 2'b00 && control[1][5:4] == 2'b00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

    property p_hsk_clears;
        @(posedge CLK) disable iff (!ARST_N)
        (state[0] == UCDMA_DONE && control[0][6] && PKT_BULK[0] && !control[0][3]
         && !(WR_EN && ADDR == UCDMA_DMA0_CONTROL)) |=> !control[0][7] && CH_IRQ[0];
    endproperty
    a_hsk_clears: assert property (p_hsk_clears) else $error("handshake did not stop");

    property p_no_hsk_runs;
        @(posedge CLK) disable iff (!ARST_N)
        (state[0] == UCDMA_DONE && !control[0][6] && control[0][7]
         && !(WR_EN && ADDR == UCDMA_DMA0_CONTROL)) |=> control[0][7] && !CH_IRQ[0];
    endproperty
    a_no_hsk_runs: assert property (p_no_hsk_runs) else $error("continuous mode stopped");

    property p_move_needs_run;
        @(posedge CLK) disable iff (!ARST_N)
        $rose(CH_MOVE[1]) |-> $past(control[1][7]) && $past(PKT_READY[1]);
    endproperty
    a_move_needs_run: assert property (p_move_needs_run) else $error("move without run");

    property p_mask_out;
        @(posedge CLK) disable iff (!ARST_N)
        (WR_EN && ADDR == UCDMA_DMA1_MASK_LOW) |=> CH_SLOT_MASK[21:14] == $past(WDATA);
    endproperty
    a_mask_out: assert property (p_mask_out) else $error("slot mask not applied");

    property p_bps_out;
        @(posedge CLK) disable iff (!ARST_N)
        (WR_EN && ADDR == UCDMA_DMA0_MASK_HIGH) |=> CH_BYTES_PER_SLOT[1:0] == $past(WDATA[7:6]);
    endproperty
    a_bps_out: assert property (p_bps_out) else $error("bytes per slot wrong");

    property p_dir_out;
        @(posedge CLK) disable iff (!ARST_N)
        (WR_EN && ADDR == UCDMA_DMA1_CONTROL) |=> CH_DIR_IN[1] == $past(WDATA[3])
            && CH_ENDPOINT[5:3] == $past(WDATA[2:0]);
    endproperty
    a_dir_out: assert property (p_dir_out) else $error("direction or endpoint wrong");

    property p_irq_pulse;
        @(posedge CLK) disable iff (!ARST_N)
        CH_IRQ[0] |=> !CH_IRQ[0];
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than a cycle");
endmodule // ucdma_channels

/* File: hdl/ucdma_pkg.sv */
// Constants for the two-channel codec DMA configuration block.
// Assumes an 8-bit memory-mapped register port at 16-bit addresses.
package ucdma_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [15:0] UCDMA_DMA0_CONTROL   = 16'hffe8;
    localparam logic [15:0] UCDMA_DMA0_MASK_HIGH = 16'hffe9;
    localparam logic [15:0] UCDMA_DMA0_MASK_LOW  = 16'hffea;
    localparam logic [15:0] UCDMA_DMA1_CONTROL   = 16'hffee;
    localparam logic [15:0] UCDMA_DMA1_MASK_HIGH = 16'hffef;
    localparam logic [15:0] UCDMA_DMA1_MASK_LOW  = 16'hfff0;
    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int UCDMA_RUN_BIT  = 7;
    localparam int UCDMA_HSK_BIT  = 6;
    localparam int UCDMA_DIR_BIT  = 3;
    localparam int UCDMA_EP_MSB   = 2;
    localparam int UCDMA_BPS_LSB  = 6;
    localparam logic [7:0] UCDMA_CTL_WMASK = 8'hcf;
    localparam logic [7:0] UCDMA_RESET_VAL = 8'h00;
    localparam int UCDMA_NUM_CH   = 2;
    // Channel sequencer states
    typedef enum logic [2:0] {
        UCDMA_IDLE = 3'b001,
        UCDMA_MOVE = 3'b010,
        UCDMA_DONE = 3'b100
    } ucdma_state_e;
endpackage

/* File: bench/ucdma_bufmgr.sv */
// Buffer manager model: offers packets, ends each move after DELAY cycles.
// Assumes CH_MOVE from the DMA block; outputs change at the falling edge.
`timescale 1ns/10ps
module ucdma_bufmgr #(
    parameter int DELAY = 3
) (
    input  wire logic       CLK,
    input  wire logic       ARST_N,
    input  wire logic [1:0] CH_MOVE,
    input  wire logic [1:0] OFFER,
    input  wire logic [1:0] BULK,
    output logic      [1:0] PKT_READY,
    output logic      [1:0] PKT_BULK,
    output logic      [1:0] PKT_DONE
);
    int   cnt [2];
    logic flip;
    // Bulk flag wanders when no packet is offered, so nobody may rely on it
    assign PKT_READY = OFFER;
    assign PKT_BULK  = (OFFER & BULK) | (~OFFER & {flip, ~flip});
    // Completion pulse a fixed delay into each move
    always @(negedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt      = '{0, 0};
            flip     = 1'b0;
            PKT_DONE = 2'h0;
        end else begin
            flip = ~flip;
            for (int c = 0; c < 2; c++) begin
                PKT_DONE[c] = CH_MOVE[c] && (cnt[c] == DELAY - 1);
                cnt[c]      = CH_MOVE[c] ? cnt[c] + 1 : 0;
            end
        end
    end
endmodule // ucdma_bufmgr

/* File: bench/tb_usb_codec_dma_channel_config.sv */
// Self-checking bench for the two-channel codec DMA configuration block.
// Assumes the buffer manager model; all inputs change at the falling edge.
`timescale 1ns/10ps
module tb_usb_codec_dma_channel_config;
    import ucdma_pkg::*;
    logic        clk = 1'b0, arst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00, rdata;
    logic [1:0]  offer = 2'h0, bulk = 2'h0, rdy, blk, dne, run, dir_in, mv, irq, mv_q;
    logic [5:0]  ep;
    logic [27:0] mask;
    logic [3:0]  bps;
    logic [15:0] regs [6] = '{UCDMA_DMA0_CONTROL, UCDMA_DMA0_MASK_HIGH, UCDMA_DMA0_MASK_LOW,
                              UCDMA_DMA1_CONTROL, UCDMA_DMA1_MASK_HIGH, UCDMA_DMA1_MASK_LOW};
    int          error_cnt = 0, total_checks = 0, cyc = 0, mv_base = 0;
    int          n_mv [2] = '{0, 0};
    int          n_irq [2] = '{0, 0};
    initial forever #2 clk = ~clk;
    ucdma_channels dut (.CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WR_EN(wr_en), .RD_EN(rd_en),
        .WDATA(wdata), .RDATA(rdata), .PKT_READY(rdy), .PKT_BULK(blk), .PKT_DONE(dne),
        .CH_RUN(run), .CH_DIR_IN(dir_in), .CH_ENDPOINT(ep), .CH_SLOT_MASK(mask),
        .CH_BYTES_PER_SLOT(bps), .CH_MOVE(mv), .CH_IRQ(irq));
    ucdma_bufmgr #(.DELAY(3)) u_mgr (.CLK(clk), .ARST_N(arst_n), .CH_MOVE(mv), .OFFER(offer),
        .BULK(bulk), .PKT_READY(rdy), .PKT_BULK(blk), .PKT_DONE(dne));
    // Count move starts and interrupt pulses; also a hang guard
    always @(posedge clk) begin
        mv_q <= mv;
        for (int c = 0; c < 2; c++) begin
            if (mv[c] === 1'b1 && mv_q[c] !== 1'b1) n_mv[c]++;
            if (irq[c] === 1'b1) n_irq[c]++;
        end
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            final_report();
        end
    end
    task automatic chk(input logic [27:0] got, input logic [27:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Strobes last one full cycle so back-to-back calls never collide
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        chk(28'(rdata), 28'(e));
    endtask
    // Wait for an interrupt count on a channel, giving up after a bound
    task automatic wait_irq(input int c, input int n);
        for (int i = 0; i < 60 && n_irq[c] < n; i++) @(negedge clk);
        @(negedge clk);
    endtask
    task automatic final_report;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        foreach (regs[i]) rd(regs[i], 8'h00);
        rd(16'hffeb, 8'h00);
        chk(28'({run, dir_in, mv, irq, ep, bps}), 28'h0);
        // Configure slots first, enable later
        wr(UCDMA_DMA0_MASK_LOW, 8'ha5);
        wr(UCDMA_DMA0_MASK_HIGH, 8'h3c);
        wr(UCDMA_DMA1_MASK_LOW, 8'h5a);
        wr(UCDMA_DMA1_MASK_HIGH, 8'hc3);
        rd(UCDMA_DMA1_MASK_HIGH, 8'hc3);
        chk(mask, {6'h03, 8'h5a, 6'h3c, 8'ha5});
        chk(28'(bps), 28'hc);
        for (int k = 0; k < 4; k++) begin
            wr(UCDMA_DMA0_MASK_HIGH, {k[1:0], 6'h2a});
            @(negedge clk);
            chk(28'(bps), {26'h3, k[1:0]});
        end
        wr(UCDMA_DMA1_CONTROL, 8'h3f);
        rd(UCDMA_DMA1_CONTROL, 8'h0f);
        chk(28'({dir_in[1], ep[5:3]}), 28'hf);
        // Endpoint codes one to seven only; zero is never programmed
        for (int k = 1; k < 8; k++) begin
            wr(UCDMA_DMA0_CONTROL, k[7:0]);
            @(negedge clk);
            chk(28'({dir_in[0], ep[2:0]}), 28'(k));
        end
        // Stands for a buffer manager that has a bulk packet ready on channel 0 before enabling
        offer = 2'b01;
        bulk = 2'b01;
        wr(UCDMA_DMA0_CONTROL, 8'hc1);
        wait_irq(0, 1);
        chk(28'({run[0], 8'(n_irq[0]), 8'(n_mv[0])}), 28'h00101);
        rd(UCDMA_DMA0_CONTROL, 8'h41);
        repeat (10) @(negedge clk);
        chk(28'(n_mv[0]), 28'h1);
        wr(UCDMA_DMA0_CONTROL, 8'hc1);
        wait_irq(0, 2);
        chk(28'({8'(n_irq[0]), 8'(n_mv[0])}), 28'h0202);
        // Handshake bit has no effect on an IN channel
        wr(UCDMA_DMA0_CONTROL, 8'hc9);
        repeat (40) @(negedge clk);
        chk(28'({run[0], 8'(n_irq[0]), n_mv[0] >= 5}), 28'h205);
        offer = 2'b11;
        bulk = 2'b11;
        wr(UCDMA_DMA1_CONTROL, 8'h82);
        repeat (40) @(negedge clk);
        chk(28'({run[1], 8'(n_irq[1]), n_mv[1] >= 4}), 28'h201);
        // Handshake on an OUT channel carrying non-bulk packets must not stop it
        bulk = 2'b10;
        wr(UCDMA_DMA0_CONTROL, 8'hc1);
        repeat (40) @(negedge clk);
        chk(28'({run[0], 8'(n_irq[0])}), 28'h102);
        // Bulk OUT with handshake off keeps moving; bulk set after the write
        wr(UCDMA_DMA0_CONTROL, 8'h81);
        bulk = 2'b11;
        mv_base = n_mv[0];
        repeat (40) @(negedge clk);
        chk(28'({run[0], 8'(n_irq[0]), n_mv[0] >= mv_base + 4}), 28'h205);
        arst_n = 1'b0;
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        chk(28'({run, mv, mask}), 28'h0);
        rd(UCDMA_DMA1_MASK_HIGH, 8'h00);
        final_report();
    end
endmodule // tb_usb_codec_dma_channel_config
